/* inc/lamp_regs.svh */
`ifndef LAMP_REGS_SVH
`define LAMP_REGS_SVH
`define LAMP_STAGES 10
`define LAMP_STAGE_MSB 9
`define LAMP_RESET_VAL 10'h000
`define LAMP_SEL_RECIRC 1'h0
`define LAMP_SEL_LOAD 1'h1
`define LAMP_ROWS 7
`define LAMP_ROW_MSB 6
`endif

/* inc/lamp_pkg.sv */
package lamp_pkg;
  typedef logic [9:0] stage_vec_type;
  typedef logic [6:0] row_vec_type;
  typedef enum logic [1:0] {
    ph_idle_type = 2'b00,
    ph_one_type = 2'b01,
    ph_two_type = 2'b10
  } phase_type;
endpackage

/* inc/lamp_link_if.sv */
`timescale 1ns/1ps
interface lamp_link_if;
  logic shift_clk;
  logic serial_data;
  logic serial_out;
  modport device (input shift_clk, input serial_data, output serial_out);
  modport ctrl (output shift_clk, output serial_data, input serial_out);
endinterface

/* rtl/lamp_register.sv */
// Function
// RL1: each clock shifts input through ten stages
// RL2: each stage drives its own output switch
// RL3: stage holding one turns switch on
// RL4: contents held while clock stands still
// RL5: single clock split into two phases
// RL6: gating recirculates when select low, loads high
// RL7: controller loads fast, then recirculates slow
// RL8: display rate at most few stages/second
// RL9: chain packages, gating only at ends
// RL10: seven rows, five columns, one space column
// RL11: one column bit per row per clock
// RL12: shift full message before trusting display
`timescale 1ns/1ps
`include "lamp_regs.svh"
module lamp_register (
  input wire logic mclk_in,
  input wire logic rst_in,
  lamp_link_if.device link,
  output logic [`LAMP_STAGE_MSB:0] lamp_on_out,
  output logic serial_out
);

  // everything the cell keeps, in one packed word
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic dat_s1;
    logic dat_s2;
    lamp_pkg::phase_type phase;
    logic master;
    lamp_pkg::stage_vec_type stages;
  } state_type;
  state_type st_r;
  state_type st_nxt;

  // two-flop pipe for one pin; result is {second, first}
  // both shift clock and data go through one, so they age alike
  function automatic logic [1:0] sync_push(
    input logic pin,
    input logic first
  );
    logic [1:0] pipe;
    pipe = {first, pin};
    return pipe;
  endfunction

  // master half opens while the synced clock is high [RL5]
  function automatic logic take_master(
    input lamp_pkg::phase_type phase,
    input logic clk_synced
  );
    logic open;
    open = (phase == lamp_pkg::ph_idle_type) && clk_synced;
    return open;
  endfunction

  // slave half opens once the synced clock is low again [RL5]
  // non-overlap: master is closed before the slave moves
  function automatic logic leave_master(
    input lamp_pkg::phase_type phase,
    input logic clk_synced
  );
    logic open;
    open = (phase == lamp_pkg::ph_one_type) && !clk_synced;
    return open;
  endfunction

  // one step toward the serial output; stage 0 takes the new bit
  function automatic lamp_pkg::stage_vec_type shift_word(
    input lamp_pkg::stage_vec_type word,
    input logic bit_in
  );
    lamp_pkg::stage_vec_type moved;
    moved = {word[`LAMP_STAGE_MSB-1:0], bit_in}; // last stage is msb [RL1]
    return moved;
  endfunction

  // the stage that leaves the package, read in two places
  function automatic logic last_stage(
    input lamp_pkg::stage_vec_type word
  );
    logic tail;
    tail = word[`LAMP_STAGE_MSB];
    return tail;
  endfunction

  // power-up has no defined pattern on the real part; here it is cleared
  function automatic state_type clear_state();
    state_type s;
    s = '0;
    s.phase = lamp_pkg::ph_idle_type;
    s.stages = `LAMP_RESET_VAL;
    return s;
  endfunction

  // codes outside the three phases go straight back to idle on the next cycle
  function automatic logic legal_phase(
    input lamp_pkg::phase_type phase
  );
    logic ok;
    ok = (phase == lamp_pkg::ph_idle_type) ||
         (phase == lamp_pkg::ph_one_type) ||
         (phase == lamp_pkg::ph_two_type);
    return ok;
  endfunction

  // phase walk: idle, master open, slave move, idle again [RL5]
  function automatic lamp_pkg::phase_type phase_after(
    input lamp_pkg::phase_type phase,
    input logic clk_synced
  );
    lamp_pkg::phase_type next;
    next = lamp_pkg::ph_idle_type;
    if (legal_phase(phase)) begin
      unique case (phase)
        lamp_pkg::ph_idle_type: begin
          if (take_master(phase, clk_synced)) begin
            next = lamp_pkg::ph_one_type;
          end else begin
            next = lamp_pkg::ph_idle_type;
          end
        end
        lamp_pkg::ph_one_type: begin
          if (leave_master(phase, clk_synced)) begin
            next = lamp_pkg::ph_two_type;
          end else begin
            next = lamp_pkg::ph_one_type;
          end
        end
        lamp_pkg::ph_two_type: begin
          next = lamp_pkg::ph_idle_type;
        end
        default: begin
          next = lamp_pkg::ph_idle_type;
        end
      endcase
    end
    return next;
  endfunction

  // master latch: catches the synced data bit on the clock's high phase
  function automatic logic master_after(
    input state_type st
  );
    logic held;
    held = st.master;
    if (take_master(st.phase, st.clk_s2)) begin
      held = st.dat_s2;
    end
    return held;
  endfunction

  // slave latches: the whole word moves once per shift clock [RL1]
  // a stopped clock leaves the word untouched for as long as it likes [RL4]
  function automatic lamp_pkg::stage_vec_type stages_after(
    input state_type st
  );
    lamp_pkg::stage_vec_type word;
    word = st.stages;
    if (st.phase == lamp_pkg::ph_two_type) begin
      word = shift_word(st.stages, st.master);
    end
    return word;
  endfunction

  // next state: pin pipes, master, slave, phase, then reset on top
  // the shift lands about four cycles after the clock falls
  always_comb begin
    st_nxt = st_r;
    {st_nxt.clk_s2, st_nxt.clk_s1} = sync_push(link.shift_clk, st_r.clk_s1);
    {st_nxt.dat_s2, st_nxt.dat_s1} = sync_push(link.serial_data, st_r.dat_s1);
    st_nxt.master = master_after(st_r);
    st_nxt.stages = stages_after(st_r);
    st_nxt.phase = phase_after(st_r.phase, st_r.clk_s2);
    if (rst_in) begin
      st_nxt = clear_state();
    end
  end

  // one register for the whole cell
  always_ff @(posedge mclk_in) begin
    st_r <= st_nxt;
  end

  // each stage drives its own lamp switch; a one conducts [RL2] [RL3]
  assign lamp_on_out = st_r.stages;
  // tail of the word, for the next package or the gating [RL9]
  assign serial_out = last_stage(st_r.stages);
  assign link.serial_out = last_stage(st_r.stages);
endmodule

/* rtl/lamp_controller.sv */
`timescale 1ns/1ps
`include "lamp_regs.svh"
module lamp_controller (
  input wire logic mclk_in,
  input wire logic rst_in,
  lamp_link_if.ctrl link,
  input wire logic [15:0] half_period_in,
  input wire logic load_sel_in,
  input wire logic new_bit_in,
  output logic shift_clk_out,
  output logic bit_taken_out
);
  typedef struct packed {
    logic ret_s1;
    logic ret_s2;
    logic [15:0] cnt;
    logic clk;
    logic data;
    logic taken;
  } state_type;
  state_type st_r;
  state_type st_nxt;

  // divider sets fast load or slow display rate [RL7] [RL8]
  always_comb begin
    st_nxt = st_r;
    st_nxt.ret_s1 = link.serial_out;
    st_nxt.ret_s2 = st_r.ret_s1;
    st_nxt.taken = 1'h0;
    if (st_r.cnt >= half_period_in) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.clk = ~st_r.clk;
      if (!st_r.clk) begin
        // one bit per clock; recirculate when select low [RL6] [RL11]
        st_nxt.data = (load_sel_in == `LAMP_SEL_LOAD) ? new_bit_in : st_r.ret_s2;
        st_nxt.taken = load_sel_in;
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    if (rst_in) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st_r <= st_nxt;
  end

  assign link.shift_clk = st_r.clk;
  assign link.serial_data = st_r.data; // gating only at chain head [RL9]
  assign shift_clk_out = st_r.clk;
  assign bit_taken_out = st_r.taken;
endmodule

/* bench/lamp_link_checker.sv */
`timescale 1ns/1ps
module lamp_link_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic shift_clk,
  input wire logic serial_data,
  input wire logic serial_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence rise_s; $rose(shift_clk); endsequence
  sequence fall_s; $fell(shift_clk); endsequence
  // the synced two-phase split needs two cycles per level
  clk_high_a: assert property (rise_s |-> shift_clk[*2]) else $error("clock high short");
  clk_low_a: assert property (fall_s |-> !shift_clk[*2]) else $error("clock low short");
  out_settle_a: assert property (rise_s |-> $stable(serial_out)[*3]) else $error("shift on rise");
  data_hold_a: assert property (rise_s |=> $stable(serial_data)[*3]) else $error("data moved");
  hold_still_a: assert property (!shift_clk[*8] |=> $stable(serial_out)) else $error("idle shift");
  reset_clear_a: assert property ($fell(rst_in) |-> !serial_out) else $error("out not clear");
endmodule

/* bench/recirculating_lamp_shift_register_tb.sv */
`timescale 1ns/1ps
module recirculating_lamp_shift_register_tb;
  logic mclk_in = 0, rst_in = 1, load_sel_in = 1, new_bit_in = 1;
  logic [9:0] lamp;
  logic sout;
  logic taken;
  int taken_n = 0;
  logic [9:0] exp_v = 10'h000;
  int mismatches = 0, checked = 0;
  lamp_link_if link_inst ();
  lamp_register lamp_register_inst (.mclk_in(mclk_in), .rst_in(rst_in), .link(link_inst),
    .lamp_on_out(lamp), .serial_out(sout));
  // slow shift clock so each level outlasts the device latency
  lamp_controller lamp_controller_inst (.mclk_in(mclk_in), .rst_in(rst_in), .link(link_inst),
    .half_period_in(16'h001f), .load_sel_in(load_sel_in), .new_bit_in(new_bit_in),
    .shift_clk_out(), .bit_taken_out(taken));
  always @(negedge mclk_in) if (taken === 1'b1) taken_n++;
  lamp_link_checker lamp_link_checker_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .shift_clk(link_inst.shift_clk), .serial_data(link_inst.serial_data), .serial_out(link_inst.serial_out));
  initial forever #10 mclk_in = ~mclk_in;
  // next stage word: new bit or recirculated last stage
  function automatic logic [9:0] nxt(logic [9:0] v, logic ld, logic b);
    return {v[8:0], ld ? b : v[9]};
  endfunction
  task automatic close_out();
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [10:0] got, logic [10:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // bounded wait; a hang ends the run as a mismatch
  task automatic wait_lvl(logic v);
    for (int n = 0; link_inst.shift_clk !== v; n++) begin
      if (n > 200) begin
        mismatches++;
        close_out();
      end
      @(negedge mclk_in);
    end
  endtask
  initial begin
    void'($urandom(32'h6039e3b6));
    repeat (16) @(negedge mclk_in);
    rst_in = 0;
    chk({sout, lamp}, 11'h000);
    // walking one first, then random load, then recirculation
    for (int i = 0; i < 36; i++) begin
      wait_lvl(1);
      exp_v = nxt(exp_v, load_sel_in, new_bit_in);
      wait_lvl(0);
      // slave half moves about four cycles after the fall
      repeat (6) @(negedge mclk_in);
      chk({sout, lamp}, {exp_v[9], exp_v});
      new_bit_in = (i >= 9 && (i % 6) != 5) ? 1'($urandom) : 1'b0; // space column
      load_sel_in = (i < 19);
    end
    chk(11'(taken_n), 11'h014);
    close_out();
  end
endmodule
